//--- sim/can_ctrl_model.sv
// CAN controller model that takes transmit frames from the scheduler.
// Assumes requests are levels held until acked; acks delay_in + 1 cycles after a request.
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model (
	input  wire logic       mclk_in,
	input  wire logic       nrst_in,
	input  wire logic       tx_req_in,
	input  wire logic [7:0] delay_in,
	output logic            tx_ack_out
);
	logic [7:0] wait_cnt;

	// Lost arbitration makes a frame wait, so the ack may come late
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wait_cnt   <= 8'h00;
			tx_ack_out <= 1'b0;
		end else begin
			tx_ack_out <= 1'b0;
			if (tx_req_in && !tx_ack_out) begin
				if (wait_cnt >= delay_in) begin
					tx_ack_out <= 1'b1;
					wait_cnt   <= 8'h00;
				end else begin
					wait_cnt <= wait_cnt + 8'h01;
				end
			end else begin
				wait_cnt <= 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the PDO parameter store and transmit scheduler.
// Assumes a 20 MHz clock and the controller model acking every frame.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pdo_pkg::*;
	localparam logic [7:0] TT_TAB [9] = '{8'h00, 8'h01, 8'hF0, 8'hFC,
		8'hFD, 8'hFE, 8'hF1, 8'hFB, 8'hFF};
	logic        mclk_in, nrst_in, od_req_in, od_wr_in, sync_in, rtr_in;
	logic        change_of_state_event_in, rx_frame_in, rx_pdo_in;
	logic        tx_ack_in, od_ack_out, od_err_out, tx_req_out, tx_ext_out;
	logic [6:0]  node_id_in;
	logic [15:0] od_index_in;
	logic [7:0]  od_sub_in, ack_dly;
	logic [31:0] od_wdata_in, od_rdata_out, rd, v;
	logic [3:0]  rtr_pdo_in, tx_pdo_out;
	logic [1:0]  rx_apply_out;
	logic [28:0] tx_id_out;
	logic [9:0]  snapshot_out, snap_at;
	int          num_errors, n_checks, seed, n;
	int          sends [N_TX];

	pdo_comm_params i_pdo_comm_params (
		.mclk_in, .nrst_in, .node_id_in, .od_req_in, .od_wr_in,
		.od_index_in, .od_sub_in, .od_wdata_in, .od_ack_out, .od_err_out,
		.od_rdata_out, .sync_in, .rtr_in, .rtr_pdo_in,
		.change_of_state_event_in, .rx_frame_in, .rx_pdo_in,
		.rx_apply_out, .tx_req_out, .tx_pdo_out, .tx_id_out, .tx_ext_out,
		.tx_ack_in, .snapshot_out
	);
	can_ctrl_model i_can_ctrl_model (
		.mclk_in, .nrst_in, .tx_req_in(tx_req_out), .delay_in(ack_dly),
		.tx_ack_out(tx_ack_in)
	);

	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end

	always @(posedge mclk_in)
		if (tx_req_out === 1'b1 && tx_ack_in === 1'b1 && tx_pdo_out < N_TX)
			sends[tx_pdo_out] <= sends[tx_pdo_out] + 1;

	function automatic logic [31:0] cob_dflt(input logic unused);
		return {unused, 2'b00, COB_BASE + {22'h00_0000, node_id_in}};
	endfunction

	task automatic chk_val(input string what, input logic [31:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic od(input logic wr, input logic [15:0] idx,
		input logic [7:0] sub, input logic [31:0] wd, input logic err);
		@(posedge mclk_in);
		od_req_in   <= 1'b1;
		od_wr_in    <= wr;
		od_index_in <= idx;
		od_sub_in   <= sub;
		od_wdata_in <= wd;
		@(posedge mclk_in);
		od_req_in <= 1'b0;
		#1;
		chk_val("od_ack", 32'h0000_0001, {31'h0, od_ack_out});
		chk_val("od_err", {31'h0, err}, {31'h0, od_err_out});
		rd = od_rdata_out;
	endtask

	// 0 sync, 1 state change, 2 remote request, 3 receive frame
	task automatic strobe(input int which, input logic [3:0] p);
		@(posedge mclk_in);
		case (which)
			0: sync_in <= 1'b1;
			1: change_of_state_event_in <= 1'b1;
			2: rtr_in <= 1'b1;
			default: rx_frame_in <= 1'b1;
		endcase
		rtr_pdo_in <= p;
		rx_pdo_in  <= p[0];
		#1 snap_at = snapshot_out;
		@(posedge mclk_in);
		{sync_in, change_of_state_event_in, rtr_in, rx_frame_in} <= 4'h0;
		#1;
	endtask

	task automatic wait_req(input logic [3:0] p, input int lim);
		for (n = 0; n < lim; n++) begin
			if (tx_req_out === 1'b1 && tx_pdo_out === p)
				break;
			@(posedge mclk_in);
			#1;
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge mclk_in);
		num_errors++;
		$display("BAD watchdog expected done seen hang");
		conclude();
	end

	initial begin
		seed = 32'hdef5;
		{nrst_in, od_req_in, od_wr_in, sync_in, rtr_in, rx_frame_in} = '0;
		{change_of_state_event_in, rx_pdo_in, rtr_pdo_in} = '0;
		{od_index_in, od_sub_in, od_wdata_in} = '0;
		node_id_in = 7'($random(seed));
		ack_dly = 8'($random(seed)) & 8'h0F;
		repeat (5) @(posedge mclk_in);
		nrst_in <= 1'b1;
		for (int p = 0; p < N_TX; p++) begin
			od(1'b0, TX_COMM_BASE + 16'(p), SUB_COB, '0, 1'b0);
			chk_val("tx id", cob_dflt(p > 1), rd);
		end
		for (int p = 0; p < N_RX; p++) begin
			od(1'b0, RX_COMM_BASE + 16'(p), SUB_COB, '0, 1'b0);
			chk_val("rx id", cob_dflt(1'b0), rd);
			od(1'b0, RX_MAP_BASE + 16'(p), SUB_COUNT, '0, 1'b0);
			chk_val("rx map count", 32'h0000_0000, rd);
		end
		od(1'b0, 16'h1402, SUB_COB, '0, 1'b1);
		od(1'b0, 16'h180A, SUB_COB, '0, 1'b1);
		od(1'b0, TX_COMM_BASE, 8'h04, '0, 1'b1);
		od(1'b1, TX_COMM_BASE, SUB_COUNT, 32'h0000_0009, 1'b1);
		od(1'b0, TX_COMM_LAST, SUB_COUNT, '0, 1'b0);
		chk_val("entries", {24'h0, COMM_ENTRIES}, rd);
		// State change reaches both enabled PDOs, lowest first
		strobe(1, 4'h0);
		wait_req(4'h0, 20);
		chk_val("tx0 sent", 32'h0000_0001, 32'(n < 20));
		chk_val("tx id out", cob_dflt(1'b0), {3'b000, tx_id_out});
		wait_req(4'h1, 40);
		chk_val("tx1 sent", 32'h0000_0001, 32'(n < 40));
		repeat (40) @(posedge mclk_in);
		chk_val("idle sends", 32'h0, 32'(sends.sum() - sends[0] - sends[1]));
		ack_dly <= 8'h00;
		od(1'b1, 16'h1801, SUB_COB, cob_dflt(1'b1), 1'b0);
		for (int p = 2; p < N_TX; p++) begin
			v = 32'($random(seed)) | 32'h8000_0000;
			od(1'b1, TX_COMM_BASE + 16'(p), SUB_COB, v, 1'b0);
			od(1'b0, TX_COMM_BASE + 16'(p), SUB_COB, '0, 1'b0);
			chk_val("cob rb", v, rd);
			v = 32'($random(seed)) & 32'h0000_FFFF;
			od(1'b1, TX_COMM_BASE + 16'(p), SUB_INHIBIT, v, 1'b0);
			od(1'b0, TX_COMM_BASE + 16'(p), SUB_INHIBIT, '0, 1'b0);
			chk_val("inhibit rb", v, rd);
			od(1'b1, TX_COMM_BASE + 16'(p), SUB_EVENT, ~v & 32'h0000_FFFF,
				1'b0);
			od(1'b0, TX_COMM_BASE + 16'(p), SUB_EVENT, '0, 1'b0);
			chk_val("event rb", ~v & 32'h0000_FFFF, rd);
		end
		for (int i = 0; i < 9; i++) begin
			od(1'b1, TX_COMM_LAST, SUB_TYPE, {24'h0, TT_TAB[i]}, i > 5);
			od(1'b0, TX_COMM_LAST, SUB_TYPE, '0, 1'b0);
			chk_val("type rb", {24'h0, i > 5 ? TT_EVENT : TT_TAB[i]}, rd);
		end
		od(1'b1, TX_COMM_BASE, SUB_TYPE, {24'h0, TT_UNSUPPORTED}, 1'b1);
		od(1'b0, TX_COMM_BASE, SUB_TYPE, '0, 1'b0);
		chk_val("type0 kept", {24'h0, TT_EVENT}, rd);
		od(1'b1, RX_MAP_BASE, 8'h01, 32'h2200_0100, 1'b1);
		od(1'b1, RX_MAP_BASE, 8'h01, 32'h2200_0310, 1'b0);
		od(1'b0, RX_MAP_BASE, 8'h01, '0, 1'b0);
		chk_val("map rb", 32'h2200_0310, rd);
		strobe(3, 4'h0);
		chk_val("rx empty", 32'h0000_0000, {30'h0, rx_apply_out});
		od(1'b1, RX_MAP_BASE, SUB_COUNT, 32'h0000_0001, 1'b0);
		strobe(3, 4'h0);
		chk_val("rx apply", 32'h0000_0001, {30'h0, rx_apply_out});
		strobe(3, 4'h1);
		chk_val("rx off", 32'h0000_0000, {30'h0, rx_apply_out});
		od(1'b1, RX_COMM_BASE, SUB_TYPE, 32'h0000_0000, 1'b0);
		strobe(3, 4'h0);
		chk_val("rx early", 32'h0000_0000, {30'h0, rx_apply_out});
		strobe(0, 4'h0);
		chk_val("rx on sync", 32'h0000_0001, {30'h0, rx_apply_out});
		// Inhibit of 0.2 ms: second send spaced by one to two 0.1 ms ticks
		od(1'b1, TX_COMM_BASE, SUB_INHIBIT, 32'h0000_0002, 1'b0);
		strobe(1, 4'h0);
		wait_req(4'h0, 20);
		repeat (3) @(posedge mclk_in);
		strobe(1, 4'h0);
		wait_req(4'h0, 5000);
		chk_val("gap ok", 32'h1, 32'(n >= 1990 && n <= 4010));
		repeat (3) @(posedge mclk_in);
		strobe(2, 4'h0);
		wait_req(4'h0, 10);
		chk_val("rtr in window", 32'h0000_0001, 32'(n < 10));
		od(1'b1, TX_COMM_BASE, SUB_INHIBIT, '0, 1'b0);
		repeat (4100) @(posedge mclk_in);
		v = (32'($random(seed)) & 32'h1FFF_FFFF) | 32'h6000_0000;
		od(1'b1, TX_COMM_BASE, SUB_COB, v, 1'b0);
		od(1'b1, TX_COMM_BASE, SUB_TYPE, {24'h0, TT_RTR_ASYNC}, 1'b0);
		chk_val("snap 253", 32'h1, {31'h0, snapshot_out[0]});
		strobe(2, 4'h0);
		wait_req(4'h0, 6);
		chk_val("rtr ignored", 32'h0000_0006, 32'(n));
		od(1'b1, TX_COMM_BASE, SUB_COB, v & 32'hBFFF_FFFF, 1'b0);
		strobe(2, 4'h0);
		wait_req(4'h0, 10);
		chk_val("rtr sent", 32'h0000_0001, 32'(n < 10));
		chk_val("ext id", v & 32'h3FFF_FFFF,
			{2'b00, tx_ext_out, tx_id_out});
		repeat (3) @(posedge mclk_in);
		od(1'b1, TX_COMM_BASE, SUB_TYPE, {24'h0, TT_RTR_SYNC}, 1'b0);
		strobe(0, 4'h0);
		chk_val("snap 252", 32'h1, {31'h0, snap_at[0]});
		strobe(1, 4'h0);
		wait_req(4'h0, 6);
		chk_val("252 no event", 32'h0000_0006, 32'(n));
		od(1'b1, TX_COMM_BASE, SUB_COB, cob_dflt(1'b0), 1'b0);
		od(1'b1, TX_COMM_BASE, SUB_TYPE, 32'h0000_0003, 1'b0);
		for (int s = 1; s <= 3; s++) begin
			strobe(0, 4'h0);
			wait_req(4'h0, 4);
			chk_val("cyclic", 32'(s == 3), 32'(n < 4));
		end
		repeat (3) @(posedge mclk_in);
		od(1'b1, TX_COMM_BASE, SUB_TYPE, 32'h0000_0000, 1'b0);
		for (int s = 0; s < 3; s++) begin
			strobe(s == 1, 4'h0);
			wait_req(4'h0, 4);
			chk_val("type 0", 32'(s == 2), 32'(n < 4));
		end
		repeat (3) @(posedge mclk_in);
		od(1'b1, TX_COMM_BASE, SUB_TYPE, {24'h0, TT_EVENT}, 1'b0);
		od(1'b1, TX_COMM_BASE, SUB_EVENT, 32'h0000_0001, 1'b0);
		wait_req(4'h0, 42100);
		chk_val("event timer", 32'h0000_0001, 32'(n < 42100));
		od(1'b1, TX_COMM_BASE, SUB_EVENT, '0, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire

//--- verilog/pdo_comm_params.sv
// PDO communication parameters, receive mapping and transmit scheduling.
// Assumes frames, SYNC and RTR arrive as one-cycle strobes from the
// CAN controller, and dictionary accesses as one-cycle requests.
// How it works
// [R1] Bit 31 set: PDO unused, no frames
// [R2] Bit 30 set: RTR frames ignored
// [R3] Bit 29 picks 11 or 29 bit identifier
// [R4] Identifier bits 28..0, default 0200h plus node
// [R5] Type 0: send on SYNC after change
// [R6] Types 1..240: cyclic, paced by SYNC
// [R7] Type 252: RTR send, data refreshed on SYNC
// [R8] Type 253: RTR send, data refreshed continuously
// [R9] Type 254: send on beam state change
// [R10] Subindex 03h: 16-bit inhibit in 0.1 ms
// [R11] Subindex 05h: 16-bit event timer in ms
// [R12] Mapping word: index, subindex, bit length
// [R13] Receive mapping count resets 0, disabling
// [R14] Two receive records at 1400h and 1401h
// [R15] Ten transmit records at 1800h to 1809h
// [R16] First two transmit PDOs enabled at reset
// [R17] Other eight transmit PDOs disabled at reset
// [R18] RTR sends ignore the inhibit time
// [R19] Inhibit time spaces sends of one PDO
// [R20] Inhibit window holds back every other trigger
// [R21] Event timer expiry sends without state change
// [R22] Type 0 receive data acted on after SYNC
// [R23] Cyclic send after configured SYNC count
// [R24] Type 255 refused
// [R25] 0.1 ms and 1 ms ticks drive timers
`timescale 1ns/1ps
`default_nettype none
module pdo_comm_params
	import pdo_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        nrst_in,
	input  wire logic [6:0]  node_id_in,
	input  wire logic        od_req_in,
	input  wire logic        od_wr_in,
	input  wire logic [15:0] od_index_in,
	input  wire logic [7:0]  od_sub_in,
	input  wire logic [31:0] od_wdata_in,
	output logic             od_ack_out,
	output logic             od_err_out,
	output logic      [31:0] od_rdata_out,
	input  wire logic        sync_in,
	input  wire logic        rtr_in,
	input  wire logic [3:0]  rtr_pdo_in,
	input  wire logic        change_of_state_event_in,
	input  wire logic        rx_frame_in,
	input  wire logic        rx_pdo_in,
	output logic      [1:0]  rx_apply_out,
	output logic             tx_req_out,
	output logic      [3:0]  tx_pdo_out,
	output logic      [28:0] tx_id_out,
	output logic             tx_ext_out,
	input  wire logic        tx_ack_in,
	output logic      [9:0]  snapshot_out
);
	typedef struct packed {
		logic [10:0]                         tick_cnt;
		logic [3:0]                          ms_cnt;
		logic                                tick_100us;
		logic                                tick_1ms;
		logic [N_TX-1:0][31:0]               tx_cob;
		logic [N_TX-1:0]                     tx_id_dflt;
		logic [N_TX-1:0][7:0]                tx_type;
		logic [N_TX-1:0][15:0]               tx_inhibit;
		logic [N_TX-1:0][15:0]               tx_event;
		logic [N_TX-1:0][15:0]               tx_inh_cnt;
		logic [N_TX-1:0][15:0]               tx_evt_cnt;
		logic [N_TX-1:0][7:0]                tx_sync_cnt;
		logic [N_TX-1:0]                     tx_pend;
		logic [N_TX-1:0]                     tx_rtr_pend;
		logic [N_TX-1:0]                     tx_changed;
		logic [N_RX-1:0][31:0]               rx_cob;
		logic [N_RX-1:0]                     rx_id_dflt;
		logic [N_RX-1:0][7:0]                rx_type;
		logic [N_RX-1:0][15:0]               rx_inhibit;
		logic [N_RX-1:0][15:0]               rx_event;
		logic [N_RX-1:0][7:0]                rx_map_cnt;
		logic [N_RX-1:0][N_MAP-1:0][31:0]    rx_map;
		logic [N_RX-1:0]                     rx_wait;
		logic [N_RX-1:0]                     rx_apply;
		logic                                od_ack;
		logic                                od_err;
		logic [31:0]                         od_rdata;
	} state_t;

	state_t r;
	state_t next_r;
	logic        found;
	logic [3:0]  sel;
	logic [15:0] sel_inhibit;

	function automatic logic [28:0] eff_id(input logic [31:0] cob,
			input logic dflt, input logic [6:0] node);
		eff_id = dflt ? COB_BASE + {22'h00_0000, node} : cob[28:0]; // [R4]
	endfunction

	function automatic logic type_ok(input logic [7:0] t);
		// Reserved band and the free-running type are both refused
		type_ok = !((t > TT_CYC_MAX) && (t < TT_RTR_SYNC)) &&
			(t != TT_UNSUPPORTED); // [R24]
	endfunction

	function automatic logic is_cyclic(input logic [7:0] t);
		is_cyclic = (t >= TT_CYC_MIN) && (t <= TT_CYC_MAX);
	endfunction

	// Lowest numbered PDO wins; RTR requests bypass the inhibit window
	always_comb begin
		found = 1'b0;
		sel   = 4'h0;
		for (int i = N_TX - 1; i >= 0; i--) begin
			if (!r.tx_cob[i][COB_UNUSED_BIT] && (r.tx_rtr_pend[i] || // [R1]
					(r.tx_pend[i] && r.tx_inh_cnt[i] == 16'h0000))) begin // [R18] [R20]
				found = 1'b1;
				sel   = 4'(i);
			end
		end
	end

	assign tx_req_out  = found;
	assign tx_pdo_out  = sel;
	assign tx_id_out   = eff_id(r.tx_cob[sel], r.tx_id_dflt[sel], node_id_in);
	assign tx_ext_out  = r.tx_cob[sel][COB_EXT_BIT]; // [R3]
	assign sel_inhibit = r.tx_inhibit[sel];
	assign od_ack_out   = r.od_ack;
	assign od_err_out   = r.od_err;
	assign od_rdata_out = r.od_rdata;
	assign rx_apply_out = r.rx_apply;

	generate
		for (genvar g = 0; g < N_TX; g++) begin : g_snap
			assign snapshot_out[g] =
				(r.tx_type[g] == TT_RTR_SYNC && sync_in) || // [R7]
				(r.tx_type[g] == TT_RTR_ASYNC) || // [R8]
				(r.tx_type[g] != TT_RTR_SYNC && found && tx_ack_in &&
					sel == 4'(g));
		end
	endgenerate

	always_comb begin
		logic [7:0]  t;
		logic [3:0]  slot;
		logic        rx_slot;
		logic [1:0]  msub;
		next_r = r;
		t       = 8'h00;
		slot    = od_index_in[3:0];
		rx_slot = od_index_in[0];
		msub    = 2'(od_sub_in - 8'h01);
		next_r.tick_100us = 1'b0;
		next_r.tick_1ms   = 1'b0;
		next_r.od_ack     = 1'b0;
		next_r.od_err     = 1'b0;
		next_r.rx_apply   = '0;

		// Timebase for inhibit and event counters
		if (r.tick_cnt == TICK_LAST) begin // [R25]
			next_r.tick_cnt   = 11'h000;
			next_r.tick_100us = 1'b1;
			if (r.ms_cnt == MS_LAST) begin
				next_r.ms_cnt   = 4'h0;
				next_r.tick_1ms = 1'b1;
			end else begin
				next_r.ms_cnt = r.ms_cnt + 4'h1;
			end
		end else begin
			next_r.tick_cnt = r.tick_cnt + 11'h001;
		end

		for (int i = 0; i < N_TX; i++) begin
			t = r.tx_type[i];
			if (r.tx_inh_cnt[i] != 16'h0000 && r.tick_100us)
				next_r.tx_inh_cnt[i] = r.tx_inh_cnt[i] - 16'h0001; // [R10]
			// Clear on send first so a trigger in that cycle survives
			if (found && tx_ack_in && sel == 4'(i)) begin
				next_r.tx_pend[i]     = 1'b0;
				next_r.tx_rtr_pend[i] = 1'b0;
				next_r.tx_inh_cnt[i]  = r.tx_inhibit[i]; // [R19]
				next_r.tx_evt_cnt[i]  = r.tx_event[i];
			end
			if (change_of_state_event_in) begin
				next_r.tx_changed[i] = 1'b1;
				if (t == TT_EVENT)
					next_r.tx_pend[i] = 1'b1; // [R9]
			end
			if (sync_in) begin
				// A change counts only until the next SYNC, whatever the type
				next_r.tx_changed[i] = 1'b0;
				if (t == TT_SYNC_ACYC) begin
					if (r.tx_changed[i] || change_of_state_event_in)
						next_r.tx_pend[i] = 1'b1; // [R5]
				end else if (is_cyclic(t)) begin
					if (r.tx_sync_cnt[i] + 8'h01 >= t) begin
						next_r.tx_pend[i]     = 1'b1; // [R6] [R23]
						next_r.tx_sync_cnt[i] = 8'h00;
					end else begin
						next_r.tx_sync_cnt[i] = r.tx_sync_cnt[i] + 8'h01;
					end
				end
			end
			if (t == TT_EVENT && r.tx_event[i] != 16'h0000 && r.tick_1ms) begin
				if (r.tx_evt_cnt[i] == 16'h0000) begin
					next_r.tx_evt_cnt[i] = r.tx_event[i]; // [R11]
				end else if (r.tx_evt_cnt[i] == 16'h0001) begin
					next_r.tx_pend[i]    = 1'b1; // [R21]
					next_r.tx_evt_cnt[i] = r.tx_event[i];
				end else begin
					next_r.tx_evt_cnt[i] = r.tx_evt_cnt[i] - 16'h0001;
				end
			end
			if (rtr_in && rtr_pdo_in == 4'(i) &&
					!r.tx_cob[i][COB_NO_RTR_BIT])
				next_r.tx_rtr_pend[i] = 1'b1; // [R2]
			if (r.tx_cob[i][COB_UNUSED_BIT]) begin
				next_r.tx_pend[i]     = 1'b0; // [R1]
				next_r.tx_rtr_pend[i] = 1'b0;
				next_r.tx_sync_cnt[i] = 8'h00;
			end
		end

		for (int j = 0; j < N_RX; j++) begin
			if (sync_in && r.rx_wait[j]) begin
				next_r.rx_apply[j] = 1'b1; // [R22]
				next_r.rx_wait[j]  = 1'b0;
			end
			if (rx_frame_in && rx_pdo_in == 1'(j) &&
					!r.rx_cob[j][COB_UNUSED_BIT] && // [R1]
					r.rx_map_cnt[j] != 8'h00) begin // [R13]
				if (r.rx_type[j] <= TT_CYC_MAX)
					next_r.rx_wait[j] = 1'b1; // [R22]
				else
					next_r.rx_apply[j] = 1'b1;
			end
		end

		if (od_req_in) begin
			next_r.od_ack   = 1'b1;
			next_r.od_rdata = 32'h0000_0000;
			if (od_index_in >= TX_COMM_BASE &&
					od_index_in <= TX_COMM_LAST) begin // [R15]
				case (od_sub_in)
					SUB_COUNT: begin
						next_r.od_rdata = {24'h00_0000, COMM_ENTRIES};
						next_r.od_err   = od_wr_in;
					end
					SUB_COB: begin
						next_r.od_rdata = {r.tx_cob[slot][31:29],
							eff_id(r.tx_cob[slot], r.tx_id_dflt[slot],
								node_id_in)};
						if (od_wr_in) begin
							next_r.tx_cob[slot]     = od_wdata_in;
							next_r.tx_id_dflt[slot] = 1'b0;
						end
					end
					SUB_TYPE: begin
						next_r.od_rdata = {24'h00_0000, r.tx_type[slot]};
						if (od_wr_in) begin
							if (type_ok(od_wdata_in[7:0])) begin
								next_r.tx_type[slot]     = od_wdata_in[7:0];
								next_r.tx_sync_cnt[slot] = 8'h00;
							end else begin
								next_r.od_err = 1'b1; // [R24]
							end
						end
					end
					SUB_INHIBIT: begin
						next_r.od_rdata = {16'h0000, r.tx_inhibit[slot]};
						if (od_wr_in)
							next_r.tx_inhibit[slot] = od_wdata_in[15:0]; // [R10]
					end
					SUB_EVENT: begin
						next_r.od_rdata = {16'h0000, r.tx_event[slot]};
						if (od_wr_in)
							next_r.tx_event[slot] = od_wdata_in[15:0]; // [R11]
					end
					default: next_r.od_err = 1'b1;
				endcase
			end else if (od_index_in[15:1] == RX_COMM_BASE[15:1]) begin // [R14]
				case (od_sub_in)
					SUB_COUNT: begin
						next_r.od_rdata = {24'h00_0000, COMM_ENTRIES};
						next_r.od_err   = od_wr_in;
					end
					SUB_COB: begin
						next_r.od_rdata = {r.rx_cob[rx_slot][31:29],
							eff_id(r.rx_cob[rx_slot], r.rx_id_dflt[rx_slot],
								node_id_in)};
						if (od_wr_in) begin
							next_r.rx_cob[rx_slot]     = od_wdata_in;
							next_r.rx_id_dflt[rx_slot] = 1'b0;
						end
					end
					SUB_TYPE: begin
						next_r.od_rdata = {24'h00_0000, r.rx_type[rx_slot]};
						if (od_wr_in) begin
							if (type_ok(od_wdata_in[7:0]))
								next_r.rx_type[rx_slot] = od_wdata_in[7:0];
							else
								next_r.od_err = 1'b1; // [R24]
						end
					end
					SUB_INHIBIT: begin
						next_r.od_rdata = {16'h0000, r.rx_inhibit[rx_slot]};
						if (od_wr_in)
							next_r.rx_inhibit[rx_slot] = od_wdata_in[15:0];
					end
					SUB_EVENT: begin
						// Stored only: receive PDOs run no event timer
						next_r.od_rdata = {16'h0000, r.rx_event[rx_slot]};
						if (od_wr_in)
							next_r.rx_event[rx_slot] = od_wdata_in[15:0];
					end
					default: next_r.od_err = 1'b1;
				endcase
			end else if (od_index_in[15:1] == RX_MAP_BASE[15:1]) begin
				if (od_sub_in == SUB_COUNT) begin
					next_r.od_rdata = {24'h00_0000, r.rx_map_cnt[rx_slot]};
					if (od_wr_in) begin
						if (od_wdata_in[7:0] <= 8'(N_MAP))
							next_r.rx_map_cnt[rx_slot] = od_wdata_in[7:0]; // [R13]
						else
							next_r.od_err = 1'b1;
					end
				end else if (od_sub_in >= 8'h01 && od_sub_in <= 8'(N_MAP)) begin
					next_r.od_rdata = r.rx_map[rx_slot][msub];
					// A zero-length entry can never map anything
					if (od_wr_in) begin
						if (od_wdata_in[MAP_LEN_LSB +: 8] != 8'h00)
							next_r.rx_map[rx_slot][msub] = od_wdata_in; // [R12]
						else
							next_r.od_err = 1'b1;
					end
				end else begin
					next_r.od_err = 1'b1;
				end
			end else begin
				next_r.od_err = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
			for (int i = 0; i < N_TX; i++) begin
				r.tx_cob[i] <= {~TX_ENABLED_RESET[i], 31'h0000_0000}; // [R16] [R17]
				r.tx_type[i]    <= TT_RESET;
				r.tx_inhibit[i] <= INHIBIT_RESET;
				r.tx_event[i]   <= EVENT_RESET;
			end
			r.tx_id_dflt <= '1;
			r.rx_id_dflt <= '1;
			for (int j = 0; j < N_RX; j++) begin
				r.rx_type[j]    <= TT_RESET;
				r.rx_map_cnt[j] <= MAP_CNT_RESET; // [R13]
			end
		end else begin
			r <= next_r;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_send;
		tx_req_out && tx_ack_in;
	endsequence

	sequence s_type255_write;
		od_req_in && od_wr_in && od_index_in == TX_COMM_BASE &&
			od_sub_in == SUB_TYPE && od_wdata_in[7:0] == TT_UNSUPPORTED;
	endsequence

	a_unused_silent: assert property ( // [R1]
		tx_req_out |-> !r.tx_cob[tx_pdo_out][COB_UNUSED_BIT])
		else $error("unused PDO presented for sending");
	a_rtr_ignored: assert property ( // [R2]
		rtr_in && rtr_pdo_in < 4'(N_TX) && r.tx_cob[rtr_pdo_in][COB_NO_RTR_BIT]
			&& !r.tx_rtr_pend[rtr_pdo_in]
		|=> !r.tx_rtr_pend[$past(rtr_pdo_in)])
		else $error("RTR accepted by PDO set to ignore it");
	a_inhibit_hold: assert property ( // [R20]
		tx_req_out && r.tx_inh_cnt[tx_pdo_out] != 16'h0000
		|-> r.tx_rtr_pend[tx_pdo_out])
		else $error("send inside inhibit window");
	a_inhibit_load: assert property ( // [R19]
		s_send |=> r.tx_inh_cnt[$past(tx_pdo_out)] == $past(sel_inhibit))
		else $error("inhibit window not started on send");
	a_type_refused: assert property ( // [R24]
		s_type255_write |=> od_err_out && r.tx_type[0] != TT_UNSUPPORTED)
		else $error("type 255 accepted");
	a_tick_spacing: assert property ( // [R25]
		r.tick_100us |=> !r.tick_100us [*8])
		else $error("inhibit tick too frequent");
	a_od_answer: assert property (
		od_req_in |=> od_ack_out ##1 !od_ack_out || $past(od_req_in))
		else $error("dictionary request not answered");
	a_rx_sync_wait: assert property ( // [R22]
		rx_apply_out[0] && r.rx_type[0] <= TT_CYC_MAX |-> $past(sync_in))
		else $error("synchronous receive data applied without SYNC");
	a_rx_disabled: assert property ( // [R13]
		rx_frame_in && !rx_pdo_in && r.rx_map_cnt[0] == 8'h00 && !sync_in
		|=> !rx_apply_out[0])
		else $error("receive PDO with empty mapping applied");
endmodule
`default_nettype wire

//--- verilog/pdo_pkg.sv
// Constants for the process-data-object parameter and transmit scheduler.
// Assumes one 20 MHz system clock; object offsets are dictionary indices.
package pdo_pkg;
	localparam int N_RX  = 2;
	localparam int N_TX  = 10;
	localparam int N_MAP = 4;

	// Object dictionary indices and subindices
	localparam logic [15:0] RX_COMM_BASE = 16'h1400;
	localparam logic [15:0] RX_MAP_BASE  = 16'h1600;
	localparam logic [15:0] TX_COMM_BASE = 16'h1800;
	localparam logic [15:0] TX_COMM_LAST = 16'h1809;
	localparam logic [7:0]  SUB_COUNT    = 8'h00;
	localparam logic [7:0]  SUB_COB      = 8'h01;
	localparam logic [7:0]  SUB_TYPE     = 8'h02;
	localparam logic [7:0]  SUB_INHIBIT  = 8'h03;
	localparam logic [7:0]  SUB_EVENT    = 8'h05;
	localparam logic [7:0]  COMM_ENTRIES = 8'h05;

	// Identifier entry layout
	localparam int COB_UNUSED_BIT = 31;
	localparam int COB_NO_RTR_BIT = 30;
	localparam int COB_EXT_BIT    = 29;
	localparam logic [28:0] COB_BASE = 29'h0000_0200;

	// Mapping entry layout
	localparam int MAP_INDEX_LSB = 16;
	localparam int MAP_SUB_LSB   = 8;
	localparam int MAP_LEN_LSB   = 0;

	// Transmission types
	localparam logic [7:0] TT_SYNC_ACYC   = 8'h00;
	localparam logic [7:0] TT_CYC_MIN     = 8'h01;
	localparam logic [7:0] TT_CYC_MAX     = 8'hF0;
	localparam logic [7:0] TT_RTR_SYNC    = 8'hFC;
	localparam logic [7:0] TT_RTR_ASYNC   = 8'hFD;
	localparam logic [7:0] TT_EVENT       = 8'hFE;
	localparam logic [7:0] TT_UNSUPPORTED = 8'hFF;

	// Reset values
	localparam logic [9:0]  TX_ENABLED_RESET = 10'h003;
	localparam logic [7:0]  TT_RESET         = TT_EVENT;
	localparam logic [15:0] INHIBIT_RESET    = 16'h0000;
	localparam logic [15:0] EVENT_RESET      = 16'h0000;
	localparam logic [7:0]  MAP_CNT_RESET    = 8'h00;

	// Timing
	localparam int CLK_HZ          = 20_000_000;
	localparam int INHIBIT_UNIT_NS = 100_000;
	localparam int EVENT_UNIT_NS   = 1_000_000;
	localparam int TICK_CYCLES =
		(CLK_HZ / 1_000_000) * INHIBIT_UNIT_NS / 1000;
	localparam int MS_TICKS = EVENT_UNIT_NS / INHIBIT_UNIT_NS;
	localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);
	localparam logic [3:0]  MS_LAST   = 4'(MS_TICKS - 1);
endpackage
